// ==== cpcp_cfg.svh ====
// Constants of the host-side packet protocol engine
// How it works
// - Packet is type, length, payload, then two checksum bytes.
// - Type top bits: 00 command, 01 response, 10 report, 11 error.
// - Length byte is 0 to 18 and counts the payload bytes exactly.
// - 16-bit CRC over type, length and payload, low byte first.
// - Checksum follows the last used payload byte, no padding.
// - Receiver resynchronises to the next packet with a valid checksum.
// - Host holds its next command until the previous one is acknowledged or has failed.
// - Host resends after 250 ms without answer, fails after several retries.
// - Host buffers incoming bytes and back-pressures the device while a packet is unread.
// - Host classifies every incoming packet by its type byte.
// - Code 2 carries exactly 16 bytes and is answered by 0x42, empty.
// - Link defaults to 19200 8N1 and can be switched to 115200.
`ifndef CPCP_CFG_SVH
`define CPCP_CFG_SVH
// ----------------------------------------------------------------
// Packet layout
// ----------------------------------------------------------------
`define CPCP_MAX_LEN    18
`define CPCP_PING_MAX   16
`define CPCP_FLASH_LEN  16
`define CPCP_CLS_CMD    2'h0
`define CPCP_CLS_RSP    2'h1
`define CPCP_CLS_RPT    2'h2
`define CPCP_CLS_ERR    2'h3
`define CPCP_CODE_PING  6'h00
`define CPCP_CODE_VER   6'h01
`define CPCP_CODE_FLASH 6'h02
`define CPCP_CODE_BAUD  6'h21
// ----------------------------------------------------------------
// Checksum and timing
// ----------------------------------------------------------------
`define CPCP_CRC_POLY   16'h8408
`define CPCP_CRC_INIT   16'hFFFF
`define CPCP_CRC_XOR    16'hFFFF
`define CPCP_CLK_HZ     10000000
`define CPCP_ACK_MS     250
`define CPCP_ACK_CYC    (`CPCP_ACK_MS * (`CPCP_CLK_HZ / 1000))
`define CPCP_TIMER_W    22
`define CPCP_RETRIES    3
`endif

// ==== cpcp_dev_model.sv ====
// Behavioural device model that answers the host engine's packets
`timescale 1ns/100ps
module cpcp_dev_model (
    input  wire logic         mclk,
    input  wire logic [7:0]   tx_data,
    input  wire logic         tx_valid,
    output logic              tx_ready,
    output logic [7:0]        rx_data,
    output logic              rx_valid,
    input  wire logic         rx_ready,
    input  wire logic [2:0]   mode,
    output logic [7:0]        npkt,
    output logic [127:0]      flash
);
    localparam logic [127:0] VER = "model:h0.0,v0.00";  // Arbitrary version text
    logic [7:0]   t, l, c0, c1;
    logic [143:0] d;
    logic [15:0]  crc;
    // One byte step of the reflected checksum
    function automatic logic [15:0] step(input logic [15:0] c, input logic [7:0] b);
        c = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
        return c;
    endfunction
    // Byte taken from the host when valid and ready meet at an edge
    task automatic get(output logic [7:0] b);
        do @(posedge mclk); while (!(tx_valid && tx_ready));
        b = tx_data;
    endtask
    // Byte offered until the host's FIFO takes it, then the line shows its inverse
    task automatic put(input logic [7:0] b);
        #1 rx_data = b;
        rx_valid = 1'b1;
        do @(posedge mclk); while (!rx_ready);
        #1 rx_valid = 1'b0;
        rx_data = ~b;
    endtask
    // Whole packet, optionally with a spoiled checksum
    task automatic send(input logic [7:0] ty, input logic [4:0] n, input logic [143:0] p,
                        input logic bad);
        logic [15:0] c;
        c = step(step(16'hFFFF, ty), {3'h0, n});
        for (int i = 0; i < n; i++) c = step(c, p[8*i+:8]);
        c = ~c ^ {15'h0000, bad};
        put(ty);
        put({3'h0, n});
        for (int i = 0; i < n; i++) put(p[8*i+:8]);
        put(c[7:0]);
        put(c[15:8]);
    endtask
    // Receive, check and answer one packet at a time
    initial begin
        tx_ready = 1'b1;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        npkt = 8'h00;
        flash = '0;
        forever begin
            get(t);
            get(l);
            for (int i = 0; i < l; i++) get(d[8*i+:8]);
            get(c0);
            get(c1);
            crc = step(step(16'hFFFF, t), l);
            for (int i = 0; i < l; i++) crc = step(crc, d[8*i+:8]);
            npkt = npkt + 8'h01;
            if (mode == 3'h1) repeat (120) @(posedge mclk);
            if (mode == 3'h4) begin
                put(8'h81);
                put(8'h13);
                send(8'h82, 5'h04, '0, 1'b1);
                send(8'h81, 5'h04, 144'h1234_FF03, 1'b0);
                send(8'h82, 5'h04, 144'h00F0_FF1F, 1'b0);
                for (int k = 1; k <= 12; k++) send(8'h80, 5'h01, 144'(k), 1'b0);
            end
            if ({c1, c0} == ~crc && mode != 3'h2) begin
                if (mode == 3'h3 || (t[5:0] == 6'h02 && l != 8'h10))
                    send({2'b11, t[5:0]}, 5'h00, d, 1'b0);
                else if (t[5:0] == 6'h00)
                    send(8'h40, l[4:0], d, 1'b0);
                else if (t[5:0] == 6'h01)
                    send(8'h41, 5'h10, {16'h0000, VER}, 1'b0);
                else begin
                    if (t[5:0] == 6'h02) flash = d[127:0];
                    send({2'b01, t[5:0]}, 5'h00, d, 1'b0);
                end
            end
        end
    end
endmodule

// ==== cpcp_fifo.sv ====
// Shift-register FIFO for received bytes
`timescale 1ns/100ps
module cpcp_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int CW = $clog2(DEPTH + 1);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [CW-1:0]           cnt;
        logic                    in_ready;
        logic                    out_valid;
    } cpcp_fifo_type;
    cpcp_fifo_type q_ff;
    cpcp_fifo_type nxt_q;
    // ----------------------------------------------------------------
    // Push and pop
    // ----------------------------------------------------------------
    // Head word always sits in mem[0], so read data come from a register
    always_comb begin
        nxt_q = q_ff;
        if (q_ff.out_valid && out_ready) begin
            nxt_q.mem = q_ff.mem >> W;
            nxt_q.cnt = q_ff.cnt - CW'(1);
        end
        if (in_valid && q_ff.in_ready) begin
            nxt_q.mem[nxt_q.cnt] = in_data;
            nxt_q.cnt = nxt_q.cnt + CW'(1);
        end
        nxt_q.out_valid = (nxt_q.cnt != '0);
        nxt_q.in_ready  = (nxt_q.cnt != CW'(DEPTH)); // Back-pressure to the UART
    end
    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            q_ff          <= '0;
            q_ff.in_ready <= 1'b1;
        end else begin
            q_ff <= nxt_q;
        end
    end
    assign in_ready  = q_ff.in_ready;
    assign out_valid = q_ff.out_valid;
    assign out_data  = q_ff.mem[0];
    property p_full_stall;
        @(posedge clk) disable iff (rst)
        (q_ff.cnt == CW'(DEPTH)) |-> !in_ready ##1 (q_ff.cnt <= CW'(DEPTH));
    endproperty
    a_full_stall: assert property (p_full_stall) else $error("fifo overfilled");
endmodule

// ==== cpcp_host.sv ====
// Host-side packet engine: sends commands, waits, retries, parses replies
`timescale 1ns/100ps
`include "cpcp_cfg.svh"
module cpcp_host import cpcp_pkg::*; #(
    parameter int ACK_TIMEOUT_CYC = `CPCP_ACK_CYC,
    parameter int MAX_RETRY       = `CPCP_RETRIES,
    parameter int FIFO_DEPTH      = 8
) (
    input  wire logic                     mclk,
    input  wire logic                     rst,
    input  wire logic                     cmd_valid,
    output logic                          cmd_ready,
    input  wire logic [5:0]               cmd_code,
    input  wire logic [4:0]               cmd_len,
    input  wire logic [`CPCP_MAX_LEN*8-1:0] cmd_payload,
    output logic                          cmd_done,
    output logic                          cmd_err,
    output logic                          cmd_fail,
    output logic [7:0]                    tx_data,
    output logic                          tx_valid,
    input  wire logic                     tx_ready,
    input  wire logic [7:0]               rx_data,
    input  wire logic                     rx_valid,
    output logic                          rx_ready,
    output logic                          pkt_valid,
    input  wire logic                     pkt_ready,
    output logic [7:0]                    pkt_type,
    output logic [4:0]                    pkt_len,
    output logic [`CPCP_MAX_LEN*8-1:0]    pkt_data,
    output logic                          baud_fast
);
    localparam int TW = `CPCP_TIMER_W;
    cpcp_state_type q_ff;
    cpcp_state_type nxt_q;
    logic [7:0]     fifo_data;
    logic           fifo_valid;
    logic           fifo_rd;
    // ----------------------------------------------------------------
    // Receive buffer
    // ----------------------------------------------------------------
    assign fifo_rd = !q_ff.pkt_valid; // Parser stalls while a packet is unread
    cpcp_fifo #(
        .W     (8),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clk       (mclk),
        .rst       (rst),
        .in_data   (rx_data),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_rd)
    );
    // Legal payload length for each command code
    function automatic logic len_ok(input logic [5:0] c, input logic [4:0] l);
        logic ok;
        ok = (l <= 5'(`CPCP_MAX_LEN));
        if (c == `CPCP_CODE_PING) ok = (l <= 5'(`CPCP_PING_MAX));
        if (c == `CPCP_CODE_VER) ok = (l == 5'd0);
        if (c == `CPCP_CODE_FLASH) ok = (l == 5'(`CPCP_FLASH_LEN));
        return ok;
    endfunction
    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    // Transmit sequencer, ack wait and receive parser
    always_comb begin
        logic        tx_take;
        logic        rx_take;
        logic        good;
        logic        ack;
        logic [15:0] c1;
        logic [15:0] fin;
        tx_take = q_ff.tx_valid && tx_ready;
        rx_take = fifo_valid && fifo_rd;
        good    = 1'b0;
        ack     = 1'b0;
        c1      = cpcp_crc_byte(q_ff.crc, q_ff.tx_data);
        fin     = q_ff.rcrc ^ `CPCP_CRC_XOR;
        nxt_q   = q_ff;
        nxt_q.done = 1'b0;
        nxt_q.err  = 1'b0;
        nxt_q.fail = 1'b0;
        if (q_ff.pkt_valid && pkt_ready) begin
            nxt_q.pkt_valid = 1'b0;
        end
        // Receive parser: any failure drops back to hunting for a type byte
        if (rx_take) begin
            case (q_ff.rs)
                RX_TYPE: begin
                    nxt_q.rtype = fifo_data;
                    nxt_q.rcrc  = cpcp_crc_byte(`CPCP_CRC_INIT, fifo_data);
                    nxt_q.rs    = RX_LEN;
                end
                RX_LEN: begin
                    nxt_q.rlen = fifo_data[4:0];
                    nxt_q.ridx = 5'd0;
                    nxt_q.rcrc = cpcp_crc_byte(q_ff.rcrc, fifo_data);
                    if (fifo_data > 8'(`CPCP_MAX_LEN)) begin
                        nxt_q.rs = RX_TYPE; // Oversized length, resume hunting
                    end else if (fifo_data == 8'h00) begin
                        nxt_q.rs = RX_CRCL;
                    end else begin
                        nxt_q.rs = RX_DATA;
                    end
                end
                RX_DATA: begin
                    nxt_q.rbuf[q_ff.ridx*8 +: 8] = fifo_data;
                    nxt_q.rcrc = cpcp_crc_byte(q_ff.rcrc, fifo_data);
                    nxt_q.ridx = q_ff.ridx + 5'd1;
                    if (q_ff.ridx == q_ff.rlen - 5'd1) begin
                        nxt_q.rs = RX_CRCL; // Checksum right after last byte
                    end
                end
                RX_CRCL: begin
                    nxt_q.rcrcl = fifo_data;
                    nxt_q.rs    = RX_CRCH;
                end
                RX_CRCH: begin
                    good     = ({fifo_data, q_ff.rcrcl} == fin); // Low byte first
                    nxt_q.rs = RX_TYPE; // Bad checksum: drop and rehunt
                end
                default: nxt_q.rs = RX_TYPE;
            endcase
        end
        // Every good packet goes out; only a matching reply is an ack
        if (good) begin
            nxt_q.pkt_valid = 1'b1;
            ack = (q_ff.st == TX_WAIT) && (q_ff.rtype[5:0] == q_ff.code)
                  && ((q_ff.rtype[7:6] == `CPCP_CLS_RSP)
                  || (q_ff.rtype[7:6] == `CPCP_CLS_ERR)); // Classify by type
        end
        // Transmit sequencer
        case (q_ff.st)
            TX_IDLE: begin
                if (cmd_valid && q_ff.cmd_ready) begin
                    nxt_q.code      = cmd_code;
                    nxt_q.len       = cmd_len;
                    nxt_q.retry     = 3'd0;
                    nxt_q.cmd_ready = 1'b0;
                    if (!len_ok(cmd_code, cmd_len)) begin
                        nxt_q.done      = 1'b1; // Refused without sending
                        nxt_q.err       = 1'b1;
                        nxt_q.cmd_ready = 1'b1;
                    end else begin
                        nxt_q.st       = TX_TYPE;
                        nxt_q.tx_data  = {`CPCP_CLS_CMD, cmd_code}; // Command class
                        nxt_q.tx_valid = 1'b1;
                        nxt_q.crc      = `CPCP_CRC_INIT;
                    end
                end
            end
            TX_TYPE: begin
                if (tx_take) begin
                    nxt_q.crc     = c1;
                    nxt_q.tx_data = {3'd0, q_ff.len}; // Length follows type
                    nxt_q.st      = TX_LEN;
                end
            end
            TX_LEN, TX_DATA: begin
                if (tx_take) begin
                    nxt_q.crc = c1;
                    if (q_ff.st == TX_DATA) begin
                        nxt_q.idx = q_ff.idx + 5'd1;
                    end else begin
                        nxt_q.idx = 5'd0;
                    end
                    if (nxt_q.idx == q_ff.len) begin
                        nxt_q.tx_data = 8'(c1 ^ `CPCP_CRC_XOR); // No padding
                        nxt_q.st      = TX_CRCL;
                    end else begin
                        nxt_q.tx_data = cmd_payload[nxt_q.idx*8 +: 8];
                        nxt_q.st      = TX_DATA;
                    end
                end
            end
            TX_CRCL: begin
                if (tx_take) begin
                    nxt_q.tx_data = 8'(q_ff.crc[15:8] ^ `CPCP_CRC_XOR); // High byte
                    nxt_q.st      = TX_CRCH;
                end
            end
            TX_CRCH: begin
                if (tx_take) begin
                    nxt_q.tx_valid = 1'b0;
                    nxt_q.timer    = TW'(ACK_TIMEOUT_CYC - 1);
                    nxt_q.st       = TX_WAIT;
                end
            end
            TX_WAIT: begin
                if (ack) begin
                    nxt_q.st        = TX_IDLE; // Next command only after ack
                    nxt_q.cmd_ready = 1'b1;
                    nxt_q.done      = 1'b1;
                    nxt_q.err       = (q_ff.rtype[7:6] == `CPCP_CLS_ERR);
                    if (q_ff.code == `CPCP_CODE_BAUD && q_ff.rtype[7:6] == `CPCP_CLS_RSP) begin
                        nxt_q.baud_fast = (cmd_payload[7:0] != 8'h00);
                    end
                end else if (q_ff.timer != '0) begin
                    nxt_q.timer = q_ff.timer - TW'(1);
                end else if (q_ff.retry == 3'(MAX_RETRY)) begin
                    nxt_q.st        = TX_IDLE; // Give up: link fault
                    nxt_q.cmd_ready = 1'b1;
                    nxt_q.done      = 1'b1;
                    nxt_q.fail      = 1'b1;
                end else begin
                    nxt_q.retry    = q_ff.retry + 3'd1; // Resend the same packet
                    nxt_q.st       = TX_TYPE;
                    nxt_q.tx_data  = {`CPCP_CLS_CMD, q_ff.code};
                    nxt_q.tx_valid = 1'b1;
                    nxt_q.crc      = `CPCP_CRC_INIT;
                end
            end
            default: nxt_q.st = TX_IDLE;
        endcase
    end
    // ----------------------------------------------------------------
    // State register and outputs
    // ----------------------------------------------------------------
    // All state in one register
    always_ff @(posedge mclk) begin
        if (rst) begin
            q_ff           <= '0;
            q_ff.st        <= TX_IDLE;
            q_ff.rs        <= RX_TYPE;
            q_ff.cmd_ready <= 1'b1;
        end else begin
            q_ff <= nxt_q;
        end
    end
    assign cmd_ready = q_ff.cmd_ready;
    assign cmd_done  = q_ff.done;
    assign cmd_err   = q_ff.err;
    assign cmd_fail  = q_ff.fail;
    assign tx_data   = q_ff.tx_data;
    assign tx_valid  = q_ff.tx_valid;
    assign pkt_valid = q_ff.pkt_valid;
    assign pkt_type  = q_ff.rtype;
    assign pkt_len   = q_ff.rlen;
    assign pkt_data  = q_ff.rbuf;
    assign baud_fast = q_ff.baud_fast;
    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_cls;
        (tx_valid && q_ff.st == TX_TYPE) |-> (tx_data[7:6] == `CPCP_CLS_CMD);
    endproperty
    a_cls: assert property (p_cls) else $error("command class wrong");
    property p_len;
        (tx_valid && q_ff.st == TX_LEN) |-> (tx_data <= 8'(`CPCP_MAX_LEN));
    endproperty
    a_len: assert property (p_len) else $error("length too large");
    property p_nopad;
        (q_ff.st == TX_LEN && tx_valid && tx_ready && q_ff.len == 5'd0) |=> (q_ff.st == TX_CRCL);
    endproperty
    a_nopad: assert property (p_nopad) else $error("checksum not after length");
    property p_crc_hi;
        (q_ff.st == TX_CRCL && tx_valid && tx_ready) |=>
            (tx_data == 8'(($past(q_ff.crc) ^ `CPCP_CRC_XOR) >> 8)) && (q_ff.st == TX_CRCH);
    endproperty
    a_crc_hi: assert property (p_crc_hi) else $error("checksum high byte wrong");
    property p_hold;
        (q_ff.st == TX_WAIT && !$past(rst)) |-> !cmd_ready && !tx_valid;
    endproperty
    a_hold: assert property (p_hold) else $error("command issued while waiting");
    property p_retry;
        (q_ff.st == TX_WAIT && q_ff.timer == '0 && !nxt_q.done
         && q_ff.retry != 3'(MAX_RETRY)) |=> (q_ff.st == TX_TYPE) && tx_valid;
    endproperty
    a_retry: assert property (p_retry) else $error("no resend on timeout");
    property p_rehunt;
        (q_ff.rs == RX_LEN && fifo_valid && fifo_rd && fifo_data > 8'(`CPCP_MAX_LEN))
            |=> (q_ff.rs == RX_TYPE) ##1 !$rose(pkt_valid);
    endproperty
    a_rehunt: assert property (p_rehunt) else $error("oversized packet kept");
    property p_report;
        ($rose(pkt_valid) && pkt_type[7:6] == `CPCP_CLS_RPT) |-> !cmd_done;
    endproperty
    a_report: assert property (p_report) else $error("report taken as ack");
    property p_flash;
        (cmd_valid && cmd_ready && cmd_code == `CPCP_CODE_FLASH
         && cmd_len != 5'(`CPCP_FLASH_LEN)) |=> cmd_done && cmd_err && !tx_valid;
    endproperty
    a_flash: assert property (p_flash) else $error("bad flash length sent");
    // Completion and reply checks
    property p_ready_done;
        $rose(cmd_ready) |-> cmd_done;
    endproperty
    a_ready_done: assert property (p_ready_done) else $error("ready without done");
    property p_fail_last;
        cmd_fail |-> cmd_done && !cmd_err && (q_ff.retry == 3'(MAX_RETRY));
    endproperty
    a_fail_last: assert property (p_fail_last) else $error("fault before last retry");
    property p_ack_pkt;
        (cmd_done && !cmd_fail && $past(q_ff.st) == TX_WAIT)
            |-> $rose(pkt_valid) && (pkt_type[5:0] == q_ff.code);
    endproperty
    a_ack_pkt: assert property (p_ack_pkt) else $error("ack code mismatch");
    property p_err_cls;
        (cmd_err && !$past(cmd_valid && cmd_ready)) |-> (pkt_type[7:6] == `CPCP_CLS_ERR);
    endproperty
    a_err_cls: assert property (p_err_cls) else $error("error without class 11");
endmodule

// ==== cpcp_pkg.sv ====
// Types and checksum function of the host-side packet engine
package cpcp_pkg;
`include "cpcp_cfg.svh"
    typedef enum logic [2:0] {
        TX_IDLE, TX_TYPE, TX_LEN, TX_DATA, TX_CRCL, TX_CRCH, TX_WAIT
    } cpcp_tx_type;
    typedef enum logic [2:0] {
        RX_TYPE, RX_LEN, RX_DATA, RX_CRCL, RX_CRCH
    } cpcp_rx_type;
    typedef struct packed {
        cpcp_tx_type             st;
        logic [5:0]              code;
        logic [4:0]              len;
        logic [4:0]              idx;
        logic [15:0]             crc;
        logic [7:0]              tx_data;
        logic                    tx_valid;
        logic [`CPCP_TIMER_W-1:0] timer;
        logic [2:0]              retry;
        logic                    cmd_ready;
        logic                    done;
        logic                    err;
        logic                    fail;
        logic                    baud_fast;
        cpcp_rx_type             rs;
        logic [7:0]              rtype;
        logic [4:0]              rlen;
        logic [4:0]              ridx;
        logic [15:0]             rcrc;
        logic [7:0]              rcrcl;
        logic [`CPCP_MAX_LEN*8-1:0] rbuf;
        logic                    pkt_valid;
    } cpcp_state_type;
    // One byte step of the reflected 16-bit CRC
    function automatic logic [15:0] cpcp_crc_byte(input logic [15:0] c,
                                                 input logic [7:0]  d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `CPCP_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction
endpackage

// ==== test_crc_packet_command_protocol.sv ====
// Self-checking testbench for the host packet engine
`timescale 1ns/100ps
module test_crc_packet_command_protocol import cpcp_pkg::*;;
    localparam int RETRY = 3;
    logic         mclk, rst, cmd_valid, cmd_ready, cmd_done, cmd_err, cmd_fail, baud_fast;
    logic         tx_valid, tx_ready, rx_valid, rx_ready, pkt_valid, pkt_ready, got_err, got_fail;
    logic [5:0]   cmd_code;
    logic [4:0]   cmd_len, pkt_len;
    logic [143:0] cmd_payload, pkt_data, p;
    logic [7:0]   tx_data, rx_data, pkt_type, npkt, n0;
    logic [2:0]   mode;
    logic [127:0] flash;
    logic [7:0]   q_type[$];
    logic [4:0]   q_len[$];
    logic [143:0] q_data[$];
    int           fail_count = 0;
    int           tests_run = 0;
    int           cyc = 0;

    cpcp_host #(.ACK_TIMEOUT_CYC(300), .MAX_RETRY(RETRY), .FIFO_DEPTH(8)) cpcp_host_inst (
        .mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_code(cmd_code), .cmd_len(cmd_len), .cmd_payload(cmd_payload),
        .cmd_done(cmd_done), .cmd_err(cmd_err), .cmd_fail(cmd_fail), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
        .pkt_type(pkt_type), .pkt_len(pkt_len), .pkt_data(pkt_data), .baud_fast(baud_fast));
    cpcp_dev_model cpcp_dev_model_inst (
        .mclk(mclk), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .mode(mode),
        .npkt(npkt), .flash(flash));

    // Clock, packet sink and hang guard
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (pkt_valid && pkt_ready) begin
            q_type.push_back(pkt_type);
            q_len.push_back(pkt_len);
            q_data.push_back(pkt_data);
        end
        if (cyc == 30000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [143:0] got, input logic [143:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One command through the handshake, waiting for its completion pulse
    task automatic cmd(input logic [5:0] c, input logic [4:0] n, input logic [143:0] d);
        int k;
        k = 0;
        q_type.delete();
        q_len.delete();
        q_data.delete();
        n0 = npkt;
        @(posedge mclk);
        #1 cmd_code = c;
        cmd_len = n;
        cmd_payload = d;
        cmd_valid = 1'b1;
        do @(posedge mclk); while (!cmd_ready);
        #1 cmd_valid = 1'b0;
        while (!cmd_done && k < 3000) begin
            @(posedge mclk);
            #1 k++;
        end
        if (k == 3000) chk(1'b0, 1'b1);
        got_err = cmd_err;
        got_fail = cmd_fail;
        @(posedge mclk);
        #1;
    endtask
    task automatic t_basic();
        for (int i = 0; i < 16; i++) p[8*i+:8] = 8'hA0 + 8'(i);
        cmd(6'h00, 5'h10, p);
        chk(q_type[0], 8'h40);
        chk(q_data[0][127:0], p[127:0]);
        cmd(6'h00, 5'h11, p);
        chk({got_err, npkt}, {1'b1, n0});
        cmd(6'h01, 5'h00, '0);
        chk({q_type[0], q_len[0]}, {8'h41, 5'h10});
        cmd(6'h02, 5'h10, p);
        chk({q_type[0], q_len[0], flash}, {8'h42, 5'h00, p[127:0]});
        cmd(6'h02, 5'h0F, p);
        chk({got_err, npkt}, {1'b1, n0});
        cmd(6'h21, 5'h01, 144'h1);
        chk({q_type[0], baud_fast}, {8'h61, 1'b1});
        cmd(6'h21, 5'h01, '0);
        chk({q_type[0], baud_fast}, {8'h61, 1'b0});
        $display("basic commands done");
    endtask
    task automatic t_faults();
        mode = 3'h3;
        cmd(6'h05, 5'h00, '0);
        chk({got_err, q_type[0]}, {1'b1, 8'hC5});
        mode = 3'h1;
        cmd(6'h06, 5'h00, '0);
        chk({got_err, got_fail, q_type[0]}, {2'b00, 8'h46});
        mode = 3'h2;
        cmd(6'h07, 5'h00, '0);
        chk({got_fail, npkt - n0}, {1'b1, 8'(1 + RETRY)});
        $display("fault handling done");
    endtask
    task automatic t_reports();
        int k;
        k = 0;
        mode = 3'h4;
        pkt_ready = 1'b0;
        fork
            cmd(6'h08, 5'h00, '0);
            begin
                while (rx_ready && k < 1000) begin
                    @(posedge mclk);
                    #1 k++;
                end
                chk(rx_ready, 1'b0);
                repeat (20) @(posedge mclk);
                #1 pkt_ready = 1'b1;
            end
        join
        chk(q_type.size(), 15);
        chk({q_type[0], q_data[0][31:0]}, {8'h81, 32'h1234_FF03});
        chk({q_type[1], q_data[1][31:0]}, {8'h82, 32'h00F0_FF1F});
        for (int i = 2; i < 14; i++) begin
            chk({q_type[i], q_data[i][7:0]}, {8'h80, 8'(i - 1)});
        end
        chk(q_type[14], 8'h48);
        mode = 3'h0;
        $display("report interleave done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Reset, then the scenarios in turn
    initial begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_code = 6'h00;
        cmd_len = 5'h00;
        cmd_payload = '0;
        pkt_ready = 1'b1;
        mode = 3'h0;
        p = '0;
        repeat (4) @(posedge mclk);
        #1 rst = 1'b0;
        chk({cmd_ready, rx_ready, tx_valid, pkt_valid, baud_fast, cmd_done, cmd_err, cmd_fail},
            8'hC0);
        t_basic();
        t_faults();
        t_reports();
        tally_and_finish();
    end
endmodule
